/* File: verilog/smpcs_consts.svh */
// Constants for the servo mode and position command select block
`ifndef SMPCS_CONSTS_SVH
`define SMPCS_CONSTS_SVH
`define SMPCS_ADDR_MODE        12'h000
`define SMPCS_ADDR_PFMT        12'h004
`define SMPCS_ADDR_IN8FN       12'h008
`define SMPCS_ADDR_STATUS      12'h00c
`define SMPCS_ADDR_TRIG        12'h010
`define SMPCS_ADDR_PATHSEL     12'h014
`define SMPCS_ADDR_PWLO        12'h018
`define SMPCS_ADDR_PWHI        12'h01c
`define SMPCS_ADDR_POS         12'h020
`define SMPCS_ADDR_TARGET      12'h024
`define SMPCS_ADDR_FILT        12'h028
`define SMPCS_ADDR_GEAR_NUM    12'h02c
`define SMPCS_ADDR_GEAR_DEN    12'h030
`define SMPCS_MODE_RESET       4'h0
`define SMPCS_MODE_RSVD        4'hb
`define SMPCS_FN_TRIG          8'h08
`define SMPCS_FN_POS0          8'h11
`define SMPCS_FN_POS1          8'h12
`define SMPCS_FN_POS2          8'h13
`define SMPCS_FN_POS3          8'h1a
`define SMPCS_FN_POS4          8'h1b
`define SMPCS_FN_POS5          8'h1c
`define SMPCS_FN_POS6          8'h1e
`define SMPCS_FN_INHIBIT       8'h45
`define SMPCS_IN8FN_RESET      8'h00
`define SMPCS_NUM_PATHS        99
`define SMPCS_PATH_HOMING      7'h00
`define SMPCS_PULSE_MPPS       4
`define SMPCS_CLK_MHZ          40
`define SMPCS_PULSE_MIN_CYC    ((`SMPCS_CLK_MHZ) / (2 * `SMPCS_PULSE_MPPS))
`define SMPCS_GEAR_NUM_RESET   32'h0100_0000
`define SMPCS_GEAR_DEN_RESET   32'h0001_86a0
`endif

/* File: verilog/smpcs_pkg.sv */
// Types for the servo mode and position command select block
package smpcs_pkg;
    typedef enum logic [1:0] {
        SMPCS_FMT_PULSE_DIR = 2'h0,
        SMPCS_FMT_CW_CCW    = 2'h1,
        SMPCS_FMT_QUAD      = 2'h2
    } smpcs_fmt_t;
    typedef enum logic [3:0] {
        SMPCS_CM_PT     = 4'b0001,
        SMPCS_CM_PR     = 4'b0010,
        SMPCS_CM_SPEED  = 4'b0100,
        SMPCS_CM_TORQUE = 4'b1000
    } smpcs_cmode_t;
endpackage : smpcs_pkg

/* File: verilog/smpcs_pulse_decode.sv */
// Pulse command decoder for the three input formats
`timescale 1ns/1ps
module smpcs_pulse_decode (
    // Clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_reset_n,
    // Synchronised pin levels and format
    input  wire logic               i_pa,
    input  wire logic               i_pb,
    input  wire smpcs_pkg::smpcs_fmt_t i_fmt,
    input  wire logic               i_neg_logic,
    input  wire logic               i_enable,
    // Count step
    output logic                    o_step,
    output logic                    o_dir_neg
);
    import smpcs_pkg::*;
    logic a_lvl;
    logic b_lvl;
    logic a_prev;
    logic b_prev;
    logic next_step;
    logic next_neg;
    assign a_lvl = i_pa ^ i_neg_logic;
    assign b_lvl = i_pb ^ i_neg_logic;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            a_prev <= 1'b0;
            b_prev <= 1'b0;
        end else begin
            a_prev <= a_lvl;
            b_prev <= b_lvl;
        end
    end

    // One step per clock at most; 4 Mpps fits the 40 MHz sampling
    always_comb begin
        next_step = 1'b0;
        next_neg  = 1'b0;
        unique case (i_fmt)
            SMPCS_FMT_PULSE_DIR: begin
                next_step = a_lvl & ~a_prev;
                next_neg  = b_lvl;
            end
            SMPCS_FMT_CW_CCW: begin
                next_step = (a_lvl & ~a_prev) ^ (b_lvl & ~b_prev);
                next_neg  = b_lvl & ~b_prev;
            end
            SMPCS_FMT_QUAD: begin
                next_step = (a_lvl ^ a_prev) ^ (b_lvl ^ b_prev);
                // Forward when the new A level differs from the old B level
                next_neg  = ~(a_lvl ^ b_prev);
            end
            default: begin
                next_step = 1'b0;
                next_neg  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_step    <= 1'b0;
            o_dir_neg <= 1'b0;
        end else begin
            o_step    <= next_step & i_enable;
            o_dir_neg <= next_neg;
        end
    end
endmodule : smpcs_pulse_decode

/* File: verilog/smpcs_top.sv */
// Mode decode and position command front end with APB registers
`timescale 1ns/1ps
`include "smpcs_consts.svh"
module smpcs_top (
    // Clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_RESET_N,
    // APB slave
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [11:0] I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic [31:0]      O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    // Terminal pins
    input  wire logic        I_PULSE_A,
    input  wire logic        I_PULSE_B,
    input  wire logic        I_SERVO_ON,
    input  wire logic        I_MODE_SEL,
    input  wire logic        I_MODE_SEL2,
    input  wire logic [6:0]  I_PATH_SEL,
    input  wire logic        I_TRIGGER,
    input  wire logic        I_INPUT8,
    // Command outputs
    output smpcs_pkg::smpcs_cmode_t O_CTRL_MODE,
    output logic             O_PATH_START,
    output logic             O_HOMING_START,
    output logic [6:0]       O_PATH_INDEX,
    output logic [31:0]      O_POS_CMD,
    output logic             O_FILTER_SCURVE,
    output logic [31:0]      O_GEAR_NUM,
    output logic [31:0]      O_GEAR_DEN
);
    import smpcs_pkg::*;

    logic [3:0]  mode_param = `SMPCS_MODE_RESET;
    logic [3:0]  active_mode;
    logic        mode_latched;
    logic [2:0]  pulse_fmt;
    logic [7:0]  in8_fn;
    logic [6:0]  pathsel_reg;
    logic [31:0] path_lo [1:`SMPCS_NUM_PATHS];
    logic [31:0] path_hi [1:`SMPCS_NUM_PATHS];
    logic [31:0] position;
    logic [31:0] target;
    logic        filt_sel;
    logic [31:0] gear_num;
    logic [31:0] gear_den;
    logic        rsvd_seen;
    logic [8:0]  s1;
    logic [8:0]  s2;
    logic        trig_prev;
    logic        trig_in;
    logic        wr;
    logic        rd_ok;
    logic        is_pt;
    logic        is_pr;
    logic        inhibit;
    logic        step;
    logic        step_neg;
    logic        dio_start;
    logic        com_start;
    logic [6:0]  start_idx;
    logic        start;
    logic [31:0] next_target;
    smpcs_cmode_t next_cmode;

    // Two-flop synchronisers for every pin
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            s1 <= 9'h000;
            s2 <= 9'h000;
        end else begin
            s1 <= {I_PULSE_A, I_PULSE_B, I_PATH_SEL};
            s2 <= s1;
        end
    end
    logic       on_s;
    logic       trig_s;
    logic       in8_s;
    logic       msel_s;
    logic       msel2_s;
    logic [4:0] aux1;
    logic [4:0] aux2;
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            aux1 <= 5'h00;
            aux2 <= 5'h00;
        end else begin
            aux1 <= {I_SERVO_ON, I_TRIGGER, I_INPUT8, I_MODE_SEL, I_MODE_SEL2};
            aux2 <= aux1;
        end
    end
    assign {on_s, trig_s, in8_s, msel_s, msel2_s} = aux2;

    // Mode code taken once after reset release, which models a power cycle
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            active_mode  <= `SMPCS_MODE_RESET;
            mode_latched <= 1'b0;
        end else if (!mode_latched) begin
            mode_latched <= 1'b1;
            if (mode_param != `SMPCS_MODE_RSVD) begin
                active_mode <= mode_param;
            end
        end
    end

    // Register writes; the mode code sits apart since it outlives reset
    assign wr    = I_PSEL & I_PENABLE & I_PWRITE;
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            pulse_fmt  <= 3'h0;
            in8_fn     <= `SMPCS_IN8FN_RESET;
            filt_sel   <= 1'b0;
            gear_num   <= `SMPCS_GEAR_NUM_RESET;
            gear_den   <= `SMPCS_GEAR_DEN_RESET;
            pathsel_reg <= 7'h00;
            rsvd_seen  <= 1'b0;
        end else if (wr) begin
            unique case (I_PADDR)
                `SMPCS_ADDR_MODE: begin
                    if (I_PWDATA[3:0] == `SMPCS_MODE_RSVD) begin
                        rsvd_seen <= 1'b1;
                    end
                end
                `SMPCS_ADDR_PFMT: pulse_fmt <= I_PWDATA[2:0];
                `SMPCS_ADDR_IN8FN: in8_fn <= I_PWDATA[7:0];
                `SMPCS_ADDR_PATHSEL: pathsel_reg <= I_PWDATA[6:0];
                `SMPCS_ADDR_FILT: filt_sel <= I_PWDATA[0];
                `SMPCS_ADDR_GEAR_NUM: gear_num <= I_PWDATA;
                `SMPCS_ADDR_GEAR_DEN: gear_den <= I_PWDATA;
                default: begin
                end
            endcase
        end
    end

    // Non-volatile mode code: kept through reset, applied at the next one
    always_ff @(posedge I_CLK) begin
        if (wr && I_PADDR == `SMPCS_ADDR_MODE
            && I_PWDATA[3:0] != `SMPCS_MODE_RSVD) begin
            mode_param <= I_PWDATA[3:0];
        end
    end

    // Stored paths; lo word holds control (bit0 incremental), hi the data
    genvar gp;
    generate
        for (gp = 1; gp <= `SMPCS_NUM_PATHS; gp++) begin : g_path
            always_ff @(posedge I_CLK or negedge I_RESET_N) begin
                if (!I_RESET_N) begin
                    path_lo[gp] <= 32'h0000_0000;
                    path_hi[gp] <= 32'h0000_0000;
                end else if (wr && pathsel_reg == 7'(gp)) begin
                    if (I_PADDR == `SMPCS_ADDR_PWLO) begin
                        path_lo[gp] <= I_PWDATA;
                    end
                    if (I_PADDR == `SMPCS_ADDR_PWHI) begin
                        path_hi[gp] <= I_PWDATA;
                    end
                end
            end
        end
    endgenerate

    // Control mode selection from active code and select inputs
    always_comb begin
        next_cmode = SMPCS_CM_PT;
        unique case (active_mode)
            4'h0: next_cmode = SMPCS_CM_PT;
            4'h1: next_cmode = SMPCS_CM_PR;
            4'h2, 4'h4: next_cmode = SMPCS_CM_SPEED;
            4'h3, 4'h5: next_cmode = SMPCS_CM_TORQUE;
            4'h6: next_cmode = msel_s ? SMPCS_CM_SPEED : SMPCS_CM_PT;
            4'h7: next_cmode = msel_s ? SMPCS_CM_TORQUE : SMPCS_CM_PT;
            4'h8: next_cmode = msel_s ? SMPCS_CM_SPEED : SMPCS_CM_PR;
            4'h9: next_cmode = msel_s ? SMPCS_CM_TORQUE : SMPCS_CM_PR;
            4'ha: next_cmode = msel_s ? SMPCS_CM_TORQUE : SMPCS_CM_SPEED;
            4'hc: next_cmode = SMPCS_CM_PR;
            4'hd: next_cmode = msel_s ? SMPCS_CM_PR : SMPCS_CM_PT;
            4'he: next_cmode = msel2_s ? SMPCS_CM_SPEED
                             : (msel_s ? SMPCS_CM_PR : SMPCS_CM_PT);
            4'hf: next_cmode = msel2_s ? SMPCS_CM_TORQUE
                             : (msel_s ? SMPCS_CM_PR : SMPCS_CM_PT);
            default: next_cmode = SMPCS_CM_PT;
        endcase
    end
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_CTRL_MODE <= SMPCS_CM_PT;
        end else begin
            O_CTRL_MODE <= next_cmode;
        end
    end
    assign is_pt = (O_CTRL_MODE == SMPCS_CM_PT);
    assign is_pr = (O_CTRL_MODE == SMPCS_CM_PR);

    // Inhibit only when input 8 carries the inhibit function
    assign inhibit = is_pt & in8_s & (in8_fn == `SMPCS_FN_INHIBIT);

    smpcs_pulse_decode u_dec (
        .i_clk       (I_CLK),
        .i_reset_n   (I_RESET_N),
        .i_pa        (s2[8]),
        .i_pb        (s2[7]),
        .i_fmt       (smpcs_fmt_t'(pulse_fmt[1:0])),
        .i_neg_logic (pulse_fmt[2]),
        .i_enable    (is_pt & on_s & ~inhibit),
        .o_step      (step),
        .o_dir_neg   (step_neg)
    );

    // Trigger edge and path index sampled together
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            trig_prev <= 1'b0;
        end else begin
            trig_prev <= trig_in;
        end
    end
    // Input 8 may carry the trigger function, ORed with the trigger pin
    assign trig_in   = trig_s | (in8_s & (in8_fn == `SMPCS_FN_TRIG));
    assign dio_start = is_pr & on_s & trig_in & ~trig_prev;
    assign com_start = wr & (I_PADDR == `SMPCS_ADDR_TRIG) & is_pr & on_s;
    assign start_idx = com_start ? I_PWDATA[6:0] : s2[6:0];
    assign start     = (dio_start | com_start)
                     & (start_idx <= 7'(`SMPCS_NUM_PATHS));

    always_comb begin
        next_target = target;
        if (start && start_idx != `SMPCS_PATH_HOMING) begin
            if (path_lo[start_idx][0]) begin
                next_target = position + path_hi[start_idx];
            end else begin
                next_target = path_hi[start_idx];
            end
        end else if (start) begin
            next_target = 32'h0000_0000;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_PATH_START   <= 1'b0;
            O_HOMING_START <= 1'b0;
            O_PATH_INDEX   <= 7'h00;
            target         <= 32'h0000_0000;
        end else begin
            O_PATH_START   <= start & (start_idx != `SMPCS_PATH_HOMING);
            O_HOMING_START <= start & (start_idx == `SMPCS_PATH_HOMING);
            target         <= next_target;
            if (start) begin
                O_PATH_INDEX <= start_idx;
            end
        end
    end

    // Pulse accumulation in pulse mode, target follow in path mode
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            position <= 32'h0000_0000;
        end else if (is_pt && step) begin
            position <= step_neg ? position - 32'h1 : position + 32'h1;
        end else if (is_pr) begin
            position <= target;
        end
    end
    assign O_POS_CMD       = position;
    assign O_FILTER_SCURVE = filt_sel;
    assign O_GEAR_NUM      = gear_num;
    assign O_GEAR_DEN      = gear_den;

    // APB read: zero-wait slave
    always_comb begin
        rd_ok    = 1'b1;
        O_PRDATA = 32'h0000_0000;
        unique case (I_PADDR)
            `SMPCS_ADDR_MODE: O_PRDATA = {28'h0, mode_param};
            `SMPCS_ADDR_PFMT: O_PRDATA = {29'h0, pulse_fmt};
            `SMPCS_ADDR_IN8FN: O_PRDATA = {24'h0, in8_fn};
            `SMPCS_ADDR_STATUS: O_PRDATA = {16'h0000, rsvd_seen, O_PATH_INDEX,
                                            active_mode, O_CTRL_MODE};
            `SMPCS_ADDR_TRIG: O_PRDATA = {25'h0, O_PATH_INDEX};
            `SMPCS_ADDR_PATHSEL: O_PRDATA = {25'h0, pathsel_reg};
            `SMPCS_ADDR_POS: O_PRDATA = position;
            `SMPCS_ADDR_TARGET: O_PRDATA = target;
            `SMPCS_ADDR_FILT: O_PRDATA = {31'h0, filt_sel};
            `SMPCS_ADDR_GEAR_NUM: O_PRDATA = gear_num;
            `SMPCS_ADDR_GEAR_DEN: O_PRDATA = gear_den;
            `SMPCS_ADDR_PWLO, `SMPCS_ADDR_PWHI: O_PRDATA = 32'h0000_0000;
            default: rd_ok = 1'b0;
        endcase
    end
    assign O_PREADY  = 1'b1;
    assign O_PSLVERR = I_PSEL & I_PENABLE & ~rd_ok;

    a_mode_rsvd_kept: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        mode_latched |-> active_mode != `SMPCS_MODE_RSVD)
        else $error("reserved mode became active");
    a_trig_edge_start: assert property (@(posedge I_CLK)
        disable iff (!I_RESET_N)
        (O_PATH_START || O_HOMING_START) |->
            $past(com_start) || ($past(trig_in) && !$past(trig_prev)))
        else $error("path started without trigger edge");
    a_inhibit_blocks: assert property (@(posedge I_CLK)
        disable iff (!I_RESET_N)
        inhibit |=> !step)
        else $error("pulse counted while inhibited");
    a_index_latched: assert property (@(posedge I_CLK)
        disable iff (!I_RESET_N)
        start && !com_start |=> O_PATH_INDEX == $past(s2[6:0]))
        else $error("path index not sampled at trigger");
    a_homing_zero: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        O_HOMING_START |-> O_PATH_INDEX == `SMPCS_PATH_HOMING)
        else $error("homing with nonzero index");
    a_index_range: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        O_PATH_START |-> O_PATH_INDEX <= 7'(`SMPCS_NUM_PATHS))
        else $error("path index out of range");
    a_pos_step: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        is_pt && step && !step_neg |=> position == $past(position) + 32'h1)
        else $error("pulse not counted");
    a_mode_dual_sel: assert property (@(posedge I_CLK)
        disable iff (!I_RESET_N)
        active_mode == 4'h6 && msel_s |=> O_CTRL_MODE == SMPCS_CM_SPEED)
        else $error("dual mode select ignored");
endmodule : smpcs_top

/* File: bench/smpcs_host_model.sv */
// Host controller model driving pulse pins and digital inputs
`timescale 1ns/1ps
`include "smpcs_consts.svh"
module smpcs_host_model (
    // Clock
    input  wire logic       i_clk,
    // Pins toward the drive
    output logic            o_pulse_a,
    output logic            o_pulse_b,
    output logic            o_servo_on,
    output logic            o_mode_sel,
    output logic            o_mode_sel2,
    output logic [6:0]      o_path_sel,
    output logic            o_trigger,
    output logic            o_input8
);
    import smpcs_pkg::*;
    logic [1:0] qs = 2'h0;
    initial begin
        {o_pulse_a, o_pulse_b, o_servo_on, o_mode_sel} = 4'h0;
        {o_mode_sel2, o_trigger, o_input8} = 3'h0;
        o_path_sel = 7'h00;
    end
    // Levels {a,b} of the quadrature states, A leading B going forward
    function automatic logic [1:0] quad_lv(input logic [1:0] s);
        case (s)
            2'h0: return 2'h0;
            2'h1: return 2'h2;
            2'h2: return 2'h3;
            default: return 2'h1;
        endcase
    endfunction : quad_lv
    // Each level stands for the shortest time allowed at the top rate
    task automatic drive(input logic a, input logic b, input logic neg);
        @(posedge i_clk);
        o_pulse_a <= a ^ neg;
        o_pulse_b <= b ^ neg;
        repeat (`SMPCS_PULSE_MIN_CYC - 1) @(posedge i_clk);
    endtask : drive
    task automatic idle(input logic [1:0] fmt, input logic neg);
        logic [1:0] lv;
        lv = (fmt == SMPCS_FMT_QUAD) ? quad_lv(qs) : 2'h0;
        drive(lv[1], lv[0], neg);
    endtask : idle
    task automatic pulses(input logic [1:0] fmt, input logic neg,
                          input int n, input logic fwd);
        logic [1:0] lv;
        if (fmt == SMPCS_FMT_PULSE_DIR)
            drive(1'b0, !fwd, neg);
        for (int i = 0; i < n; i++) begin
            if (fmt == SMPCS_FMT_QUAD) begin
                qs = fwd ? qs + 2'h1 : qs - 2'h1;
                lv = quad_lv(qs);
                drive(lv[1], lv[0], neg);
            end else if (fmt == SMPCS_FMT_PULSE_DIR) begin
                drive(1'b1, !fwd, neg);
                drive(1'b0, !fwd, neg);
            end else begin
                drive(fwd, !fwd, neg);
                drive(1'b0, 1'b0, neg);
            end
        end
        idle(fmt, neg);
    endtask : pulses
    task automatic servo(input logic v);
        @(posedge i_clk);
        o_servo_on <= v;
        repeat (4) @(posedge i_clk);
    endtask : servo
    task automatic sel(input logic m, input logic m2, input logic in8);
        @(posedge i_clk);
        o_mode_sel  <= m;
        o_mode_sel2 <= m2;
        o_input8    <= in8;
    endtask : sel
    // Path bits settle before the trigger rises
    task automatic trig(input logic [6:0] idx, input logic chg);
        @(posedge i_clk);
        o_path_sel <= idx;
        repeat (3) @(posedge i_clk);
        o_trigger <= 1'b1;
        if (chg) begin
            @(posedge i_clk);
            o_path_sel <= idx ^ 7'h03;
        end
    endtask : trig
    task automatic untrig;
        @(posedge i_clk);
        o_trigger <= 1'b0;
        repeat (4) @(posedge i_clk);
    endtask : untrig
endmodule : smpcs_host_model

/* File: bench/tb.sv */
// Directed testbench for the mode and position command front end
`timescale 1ns/1ps
`include "smpcs_consts.svh"
module tb;
    import smpcs_pkg::*;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, er;
    logic [11:0] addr = 12'h000;
    logic [31:0] wd = 32'h0, rd, prdata, pos, gnum, gden, ep;
    logic pready, pslverr, pstart, hstart, scurve;
    logic pa, pb, son, ms, ms2, trg, in8;
    logic [6:0] pins, pidx;
    logic [3:0] pm;
    smpcs_cmode_t cm;
    int err_count = 0, n_tests = 0;
    always #12.5 clk = ~clk;
    smpcs_host_model host (.i_clk(clk), .o_pulse_a(pa), .o_pulse_b(pb),
        .o_servo_on(son), .o_mode_sel(ms), .o_mode_sel2(ms2),
        .o_path_sel(pins), .o_trigger(trg), .o_input8(in8));
    smpcs_top dut (.I_CLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(addr), .I_PWDATA(wd),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .I_PULSE_A(pa), .I_PULSE_B(pb), .I_SERVO_ON(son), .I_MODE_SEL(ms),
        .I_MODE_SEL2(ms2), .I_PATH_SEL(pins), .I_TRIGGER(trg),
        .I_INPUT8(in8), .O_CTRL_MODE(cm), .O_PATH_START(pstart),
        .O_HOMING_START(hstart), .O_PATH_INDEX(pidx), .O_POS_CMD(pos),
        .O_FILTER_SCURVE(scurve), .O_GEAR_NUM(gnum), .O_GEAR_DEN(gden));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        {psel, pen, pwr, addr, wd} <= {2'b10, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
        if (n >= 50) err_count++;
        rd = prdata;
        er = pslverr;
        {psel, pen} <= 2'b00;
    endtask : apb
    task automatic do_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask : do_reset
    function automatic logic [3:0] expm(input int c, input logic s,
                                        input logic s2);
        case (c)
            2, 4: return SMPCS_CM_SPEED;
            3, 5: return SMPCS_CM_TORQUE;
            6: return s ? SMPCS_CM_SPEED : SMPCS_CM_PT;
            7: return s ? SMPCS_CM_TORQUE : SMPCS_CM_PT;
            8: return s ? SMPCS_CM_SPEED : SMPCS_CM_PR;
            9: return s ? SMPCS_CM_TORQUE : SMPCS_CM_PR;
            10: return s ? SMPCS_CM_TORQUE : SMPCS_CM_SPEED;
            12: return SMPCS_CM_PR;
            13: return s ? SMPCS_CM_PR : SMPCS_CM_PT;
            14: return s2 ? SMPCS_CM_SPEED : (s ? SMPCS_CM_PR : SMPCS_CM_PT);
            15: return s2 ? SMPCS_CM_TORQUE : (s ? SMPCS_CM_PR : SMPCS_CM_PT);
            default: return SMPCS_CM_PT;
        endcase
    endfunction : expm
    task automatic wait_mode(input logic [3:0] e);
        for (int n = 0; n < 12 && cm !== e; n++) @(posedge clk);
        check({28'h0, cm}, {28'h0, e});
    endtask : wait_mode
    task automatic wait_start(input logic [6:0] i, input logic h,
                              input logic [31:0] p);
        int n;
        n = 0;
        do @(posedge clk); while ((pstart | hstart) !== 1'b1 && ++n < 20);
        check({hstart, pstart, pidx}, {h, !h, i});
        repeat (2) @(posedge clk);
        check(pos, p);
    endtask : wait_start
    task automatic no_start;
        int c;
        c = 0;
        repeat (20) begin
            @(posedge clk);
            if ((pstart | hstart) !== 1'b0) c++;
        end
        check(c, 0);
    endtask : no_start
    task automatic pt_run(input logic [1:0] f, input logic ng, input int n,
                          input logic fw, input logic [31:0] e);
        host.pulses(f, ng, n, fw);
        repeat (8) @(posedge clk);
        check(pos, e);
    endtask : pt_run
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        check(gnum, `SMPCS_GEAR_NUM_RESET);
        check(gden, `SMPCS_GEAR_DEN_RESET);
        wait_mode(SMPCS_CM_PT);
        apb(1'b0, 12'h100, 32'h0);
        check(er, 1'b1);
        pm = SMPCS_CM_PT;
        for (int c = 2; c < 16; c++) begin
            apb(1'b1, `SMPCS_ADDR_MODE, c);
            repeat (3) @(posedge clk);
            check({28'h0, cm}, {28'h0, pm});
            if (c == 11) begin
                apb(1'b0, `SMPCS_ADDR_MODE, 32'h0);
                check(rd, 32'ha);
                apb(1'b0, `SMPCS_ADDR_STATUS, 32'h0);
                check(rd[15], 1'b1);
                continue;
            end
            do_reset;
            for (int s = 0; s < 4; s++) begin
                host.sel(s[0], s[1], 1'b0);
                wait_mode(expm(c, s[0], s[1]));
            end
            host.sel(1'b0, 1'b0, 1'b0);
            pm = expm(c, 1'b0, 1'b0);
        end
        apb(1'b1, `SMPCS_ADDR_MODE, 32'h1);
        do_reset;
        wait_mode(SMPCS_CM_PR);
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, `SMPCS_ADDR_PATHSEL, k == 0 ? 5 : (k == 1 ? 6 : 99));
            apb(1'b1, `SMPCS_ADDR_PWLO, k == 1);
            apb(1'b1, `SMPCS_ADDR_PWHI, k == 0 ? 32'h1234 :
                (k == 1 ? 32'h10 : 32'habc));
        end
        host.servo(1'b1);
        host.trig(7'd5, 1'b0);
        wait_start(7'd5, 1'b0, 32'h1234);
        no_start;
        host.untrig;
        host.trig(7'd6, 1'b1);
        wait_start(7'd6, 1'b0, 32'h1244);
        host.untrig;
        host.trig(7'd99, 1'b0);
        wait_start(7'd99, 1'b0, 32'habc);
        host.untrig;
        host.trig(`SMPCS_PATH_HOMING, 1'b0);
        wait_start(`SMPCS_PATH_HOMING, 1'b1, 32'h0);
        host.untrig;
        apb(1'b1, `SMPCS_ADDR_TRIG, 32'h6);
        wait_start(7'd6, 1'b0, 32'h10);
        apb(1'b1, `SMPCS_ADDR_TRIG, 32'd100);
        no_start;
        apb(1'b1, `SMPCS_ADDR_IN8FN, `SMPCS_FN_TRIG);
        host.sel(1'b0, 1'b0, 1'b1);
        wait_start(`SMPCS_PATH_HOMING, 1'b1, 32'h0);
        host.sel(1'b0, 1'b0, 1'b0);
        host.servo(1'b0);
        apb(1'b1, `SMPCS_ADDR_MODE, 32'h0);
        do_reset;
        wait_mode(SMPCS_CM_PT);
        ep = 32'h0;
        for (int f = 0; f < 3; f++) begin
            for (int ng = 0; ng < 2; ng++) begin
                apb(1'b1, `SMPCS_ADDR_PFMT, {ng[0], f[1:0]});
                host.idle(f[1:0], ng[0]);
                host.servo(1'b1);
                ep = ep + 32'd6;
                pt_run(f[1:0], ng[0], 6, 1'b1, ep);
                ep = ep - 32'd4;
                pt_run(f[1:0], ng[0], 4, 1'b0, ep);
                host.servo(1'b0);
            end
        end
        apb(1'b1, `SMPCS_ADDR_PFMT, 32'h0);
        host.idle(2'h0, 1'b0);
        apb(1'b1, `SMPCS_ADDR_IN8FN, `SMPCS_FN_INHIBIT);
        host.sel(1'b0, 1'b0, 1'b1);
        host.servo(1'b1);
        pt_run(2'h0, 1'b0, 5, 1'b1, ep);
        apb(1'b1, `SMPCS_ADDR_IN8FN, `SMPCS_IN8FN_RESET);
        ep = ep + 32'd5;
        pt_run(2'h0, 1'b0, 5, 1'b1, ep);
        host.sel(1'b0, 1'b0, 1'b0);
        apb(1'b1, `SMPCS_ADDR_GEAR_DEN, 32'h3a98);
        apb(1'b1, `SMPCS_ADDR_FILT, 32'h1);
        repeat (3) @(posedge clk);
        check({scurve, gden}, {1'b1, 32'h3a98});
        print_verdict;
    end
    initial begin
        #1000000;
        err_count++;
        print_verdict;
    end
endmodule : tb
